/* include/asfb_pkg.sv */
package asfb_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRLA0   = 8'h00;
  localparam logic [7:0] IDX_CTRLA1   = 8'h01;
  localparam logic [7:0] IDX_CTRLB0   = 8'h02;
  localparam logic [7:0] IDX_CTRLB1   = 8'h03;
  localparam logic [7:0] IDX_IRQSTAT  = 8'h04;
  localparam logic [7:0] IDX_IRQMASK  = 8'h05;
  localparam logic [7:0] IDX_PINSEL   = 8'h06;

  // ==========================================================================
  // Field positions of control register B.
  localparam int CB_MPTX  = 7;
  localparam int CB_MPFMT = 6;
  localparam int CB_CLRPS = 5;
  localparam int CB_ODD   = 4;
  localparam int CB_DIV   = 3;
  localparam int CB_SS    = 0;
  // Field positions of control register A and the pin select register.
  localparam int CA_WAKE  = 7;
  localparam int CA_CKDMA = 4;
  localparam int CA_LEN   = 2;
  localparam int CA_PEN   = 1;
  localparam int CA_STOP  = 0;
  localparam int PS_HSEL  = 0;

  // ==========================================================================
  // Reset values and writable masks.
  localparam logic [7:0] CTRLB_RESET  = 8'h07;
  localparam logic [7:0] CTRLA_RESET  = 8'h00;
  localparam logic [7:0] CTRLA0_MASK  = 8'h87;
  localparam logic [7:0] CTRLA1_MASK  = 8'h97;
  localparam logic [3:0] IRQ_RESET    = 4'h0;

  // ==========================================================================
  // Timing counts: prescaler in system clock cycles, bit divide in sample ticks; SS_EXT is the pin clock source code.
  localparam int         PRE_LO  = 10;
  localparam int         PRE_HI  = 30;
  localparam int         SAMP_LO = 16;
  localparam int         SAMP_HI = 64;
  localparam logic [2:0] SS_EXT  = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Returns {hit, index}; an unmapped or misaligned address misses.
  function automatic logic [8:0] asfb_decode(input logic [7:0] a);
    logic [7:0] idx;
    idx = {2'h0, a[7:2]};
    if (a[1:0] != 2'h0) begin
      return 9'h000;
    end else if (idx <= IDX_PINSEL) begin
      return {1'b1, idx};
    end else begin
      return 9'h000;
    end
  endfunction : asfb_decode

  // Start, data, parity or marker, then stop bits.
  function automatic logic [3:0] asfb_frame_len(input logic len8, input logic pen,
                                                input logic two, input logic mp);
    return 4'h1 + (len8 ? 4'h8 : 4'h7) + ((pen | mp) ? 4'h1 : 4'h0) + (two ? 4'h2 : 4'h1);
  endfunction : asfb_frame_len

  // Parity over the data bits only; odd inverts the even result.
  function automatic logic asfb_parity(input logic [7:0] d, input logic len8,
                                       input logic odd);
    return (^{len8 & d[7], d[6:0]}) ^ odd;
  endfunction : asfb_parity

endpackage : asfb_pkg

/* hdl/asfb_sync.sv */
`timescale 1ns/10ps
module asfb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // ==========================================================================
  // Two-stage synchroniser; only the second stage is read downstream.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

  initial begin
    if (W < 1) $error("asfb_sync: width must be at least one");
  end
endmodule : asfb_sync

/* hdl/asfb_baud_gen.sv */
`timescale 1ns/10ps
module asfb_baud_gen
  import asfb_pkg::*;
#(
  parameter int CNT_W = 6
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       prescale30,
  input  wire logic [2:0] srcSpeed,
  input  wire logic       divide64,
  input  wire logic       extClk,
  output logic            sampleTick,
  output logic            bitTick
);
  logic [4:0]       preCnt_reg;
  logic [CNT_W-1:0] srcCnt_reg;
  logic [CNT_W-1:0] smpCnt_reg;
  logic             extPrev_reg;
  logic             preTick;
  logic             srcTick;
  logic             smpIn;
  logic [4:0]       preLim;
  logic [CNT_W-1:0] srcLim;
  logic [CNT_W-1:0] smpLim;

  // ==========================================================================
  // Prescaler, source divider and 16/64 divide run in a chain.
  assign preLim  = prescale30 ? 5'(PRE_HI - 1) : 5'(PRE_LO - 1);
  assign preTick = (preCnt_reg == preLim);
  assign srcLim  = CNT_W'((7'h01 << srcSpeed) - 7'h01);
  assign srcTick = preTick && (srcCnt_reg == srcLim);
  // External pin edges replace the internal chain when selected.
  assign smpIn   = (srcSpeed == SS_EXT) ? (extClk & ~extPrev_reg) : srcTick;
  assign smpLim  = divide64 ? CNT_W'(SAMP_HI - 1) : CNT_W'(SAMP_LO - 1);

  // A shortened limit after a write is caught by the >= compare.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_reg <= '0;
    end else if (preCnt_reg >= preLim) begin
      preCnt_reg <= '0;
    end else begin
      preCnt_reg <= preCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srcCnt_reg <= '0;
    end else if (preTick) begin
      srcCnt_reg <= (srcCnt_reg >= srcLim) ? '0 : srcCnt_reg + 1'b1;
    end
  end

  // Sampling clock to bit rate divide, plus registered strobes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smpCnt_reg  <= '0;
      extPrev_reg <= 1'b0;
      sampleTick  <= 1'b0;
      bitTick     <= 1'b0;
    end else begin
      extPrev_reg <= extClk;
      sampleTick  <= smpIn;
      bitTick     <= smpIn && (smpCnt_reg >= smpLim);
      if (smpIn) begin
        smpCnt_reg <= (smpCnt_reg >= smpLim) ? '0 : smpCnt_reg + 1'b1;
      end
    end
  end

  initial begin
    if (CNT_W < 6) $error("asfb_baud_gen: CNT_W must be at least 6");
  end

  property p_pre_period;
    @(posedge clk) disable iff (!arst_n)
      (preTick && !prescale30 && $stable(prescale30)) |-> ##1 !preTick [*8];
  endproperty
  a_pre_period: assert property (p_pre_period) else $error("prescale period too short");

  property p_ext_edge;
    @(posedge clk) disable iff (!arst_n)
      (srcSpeed == SS_EXT && !(extClk && !extPrev_reg)) |=> !sampleTick;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("sample tick without pin edge");
endmodule : asfb_baud_gen

/* hdl/asfb_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Data length select 0 gives seven data bits, 1 gives eight.
// - Frame is start, data, optional parity, then one or two stop bits.
// - In multiprocessor format the marker bit sent equals the transmit-bit field.
// - Multiprocessor frame carries a marker bit and never a parity bit.
// - Reset clears format, prescale, odd, divide bits; source field resets to 111.
// - Reading the clear/prescale bit returns the clear-to-send pin level.
// - Clear-to-send high holds the transmit-empty flag at zero.
// - Channel 1 clear-to-send is valid only when its pin select is 1.
// - Prescale bit 1 divides the system clock by 30, 0 by 10.
// - Odd-parity bit picks even or odd only, never enables parity.
// - Divide bit selects 16 or 64 samples per bit.
// - Source field 000..110 divides by 1..64; 111 selects the pin clock.
// - Clock pins are clock inputs; channel 0 pin is DMA request when set.
// - Channel 1 pin drives DMA end-of-transfer when its DMA select is 1.
// - Bit clock is prescaler, then source divider, then 16/64 divide.
// - Wakeup filter passes only received characters with marker bit 1.
module asfb_top
  import asfb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              ch0ClearToSendN,
  input  wire logic              ch1ClearToSendN,
  input  wire logic              ch0ClockPin,
  input  wire logic              ch1ClockPinIn,
  output logic                   ch1ClockPinOut,
  output logic                   ch1ClockPinOe,
  output logic                   ch0ClockPinIsDmaReq,
  input  wire logic              dmaCh0MemIo,
  input  wire logic              dmaEndOfTransfer,
  input  wire logic [1:0]        txHoldingEmptyRaw,
  output logic [1:0]             txHoldingEmptyFlag,
  input  wire logic [1:0][7:0]   txData,
  output logic [1:0]             txParityBit,
  input  wire logic [1:0]        rxCharDone,
  input  wire logic [1:0]        rxAddressMarker,
  output logic [1:0]             rxFlagUpdate,
  output logic [1:0]             dataLengthSelect,
  output logic [1:0]             parityActive,
  output logic [1:0]             oddParitySelect,
  output logic [1:0]             stopCountSelect,
  output logic [1:0]             multiprocFormatEnable,
  output logic [1:0]             multiprocTxBit,
  output logic [1:0][3:0]        frameLength,
  output logic [1:0]             sampleTick,
  output logic [1:0]             bitTick,
  output logic                   irq
);
  import asfb_pkg::*;

  logic [1:0][7:0] ctrlA_reg;
  logic [1:0][7:0] ctrlB_reg;
  logic            pinSel_reg;
  logic [3:0]      irqStat_reg;
  logic [3:0]      irqMask_reg;
  logic            awHeld_reg;
  logic [7:0]      awAddr_reg;
  logic            wHeld_reg;
  logic [7:0]      wData_reg;
  logic            wLane_reg;
  logic [3:0]      syncQ;
  logic [1:0]      ctsHigh;
  logic [1:0]      ctsRead;
  logic [1:0]      extClk;
  logic [1:0]      txEmptyNext;
  logic [1:0]      rxAccept;
  logic [3:0]      irqEvt;
  logic [3:0]      irqClr;
  logic            wrFire;
  logic [8:0]      wrDec;
  logic [8:0]      rdDec;
  logic [7:0]      rdByte;

  // ==========================================================================
  // Pin synchronisers: both clear-to-send pins and both clock pins.
  asfb_sync #(
    .W (4)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({ch1ClockPinIn, ch0ClockPin, ch1ClearToSendN, ch0ClearToSendN}),
    .q      (syncQ)
  );

  // Channel 1 shares its handshake pin with clocked serial receive data.
  assign ctsRead[0] = syncQ[0];
  assign ctsRead[1] = pinSel_reg & syncQ[1];
  assign ctsHigh    = ctsRead;

  // A pin taken over by the DMA controller feeds no clock edges.
  assign extClk[0] = syncQ[2] & ~dmaCh0MemIo;
  assign extClk[1] = syncQ[3] & ~ctrlA_reg[1][CA_CKDMA];

  // ==========================================================================
  // Clock pin sharing with the DMA controller.
  assign ch0ClockPinIsDmaReq = dmaCh0MemIo;
  assign ch1ClockPinOe       = ctrlA_reg[1][CA_CKDMA];
  assign ch1ClockPinOut      = ctrlA_reg[1][CA_CKDMA] & dmaEndOfTransfer;

  // ==========================================================================
  // One baud chain per channel, steered by control register B.
  for (genvar ch = 0; ch < 2; ch++) begin : g_baud
    asfb_baud_gen #(
      .CNT_W (6)
    ) u_baud (
      .clk        (clk),
      .arst_n     (arst_n),
      .prescale30 (ctrlB_reg[ch][CB_CLRPS]),
      .srcSpeed   (ctrlB_reg[ch][CB_SS+:3]),
      .divide64   (ctrlB_reg[ch][CB_DIV]),
      .extClk     (extClk[ch]),
      .sampleTick (sampleTick[ch]),
      .bitTick    (bitTick[ch])
    );
  end

  // ==========================================================================
  // Frame format outputs, registered from the control registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataLengthSelect      <= 2'h0;
      parityActive          <= 2'h0;
      oddParitySelect       <= 2'h0;
      stopCountSelect       <= 2'h0;
      multiprocFormatEnable <= 2'h0;
      multiprocTxBit        <= 2'h0;
      frameLength           <= '0;
      txParityBit           <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        dataLengthSelect[ch]      <= ctrlA_reg[ch][CA_LEN];
        // Multiprocessor format suppresses parity whatever its enable says.
        parityActive[ch]          <= ctrlA_reg[ch][CA_PEN] & ~ctrlB_reg[ch][CB_MPFMT];
        oddParitySelect[ch]       <= ctrlB_reg[ch][CB_ODD];
        stopCountSelect[ch]       <= ctrlA_reg[ch][CA_STOP];
        multiprocFormatEnable[ch] <= ctrlB_reg[ch][CB_MPFMT];
        multiprocTxBit[ch]        <= ctrlB_reg[ch][CB_MPTX];
        frameLength[ch] <= asfb_frame_len(ctrlA_reg[ch][CA_LEN], ctrlA_reg[ch][CA_PEN],
                                          ctrlA_reg[ch][CA_STOP], ctrlB_reg[ch][CB_MPFMT]);
        txParityBit[ch] <= asfb_parity(txData[ch], ctrlA_reg[ch][CA_LEN],
                                       ctrlB_reg[ch][CB_ODD]);
      end
    end
  end

  // ==========================================================================
  // Transmit-empty gating and the receive wakeup filter.
  assign txEmptyNext = txHoldingEmptyRaw & ~ctsHigh;
  for (genvar ch = 0; ch < 2; ch++) begin : g_rx
    assign rxAccept[ch] = rxCharDone[ch] & (~ctrlB_reg[ch][CB_MPFMT] | ~ctrlA_reg[ch][CA_WAKE]
                          | rxAddressMarker[ch]);
  end
  assign rxFlagUpdate = rxAccept;

  // The flag is a data output, so it is registered one cycle behind the synchronised pin.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txHoldingEmptyFlag <= 2'h0;
    end else begin
      txHoldingEmptyFlag <= txEmptyNext;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path; address and data are latched in either order.
  assign awready = ~awHeld_reg & ~bvalid;
  assign wready  = ~wHeld_reg & ~bvalid;
  assign wrFire  = awHeld_reg & wHeld_reg & ~bvalid;
  assign wrDec   = asfb_decode(awAddr_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wHeld_reg  <= 1'b0;
      wData_reg  <= 8'h00;
      wLane_reg  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= 8'(awaddr);
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata[7:0];
        wLane_reg <= wstrb[0];
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // The response waits for bready; no new write is taken meanwhile.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= wrDec[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers; only byte lane 0 carries data.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlA_reg   <= {CTRLA_RESET, CTRLA_RESET};
      ctrlB_reg   <= {CTRLB_RESET, CTRLB_RESET};
      pinSel_reg  <= 1'b0;
      irqMask_reg <= IRQ_RESET;
    end else if (wrFire && wLane_reg && wrDec[8]) begin
      if (wrDec[7:0] == IDX_CTRLA0) begin
        ctrlA_reg[0] <= wData_reg & CTRLA0_MASK;
      end else if (wrDec[7:0] == IDX_CTRLA1) begin
        ctrlA_reg[1] <= wData_reg & CTRLA1_MASK;
      end else if (wrDec[7:0] == IDX_CTRLB0) begin
        ctrlB_reg[0] <= wData_reg;
      end else if (wrDec[7:0] == IDX_CTRLB1) begin
        ctrlB_reg[1] <= wData_reg;
      end else if (wrDec[7:0] == IDX_IRQMASK) begin
        irqMask_reg <= wData_reg[3:0];
      end else if (wrDec[7:0] == IDX_PINSEL) begin
        pinSel_reg <= wData_reg[PS_HSEL];
      end
    end
  end

  // ==========================================================================
  // Sticky event bits; a new event wins over a write-one clear.
  assign irqEvt = {txEmptyNext & ~txHoldingEmptyFlag, rxAccept};
  assign irqClr = (wrFire && wLane_reg && wrDec[8] && wrDec[7:0] == IDX_IRQSTAT)
                  ? wData_reg[3:0] : 4'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_reg <= IRQ_RESET;
    end else begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvt;
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ==========================================================================
  // AXI4-Lite read path; the clear/prescale bit shows the pin, not the store.
  assign arready = ~rvalid;
  assign rdDec   = asfb_decode(8'(araddr));

  always_comb begin
    rdByte = 8'h00;
    if (rdDec[7:0] == IDX_CTRLA0) begin
      rdByte = ctrlA_reg[0];
    end else if (rdDec[7:0] == IDX_CTRLA1) begin
      rdByte = ctrlA_reg[1];
    end else if (rdDec[7:0] == IDX_CTRLB0) begin
      rdByte = {ctrlB_reg[0][7:6], ctsRead[0], ctrlB_reg[0][4:0]};
    end else if (rdDec[7:0] == IDX_CTRLB1) begin
      rdByte = {ctrlB_reg[1][7:6], ctsRead[1], ctrlB_reg[1][4:0]};
    end else if (rdDec[7:0] == IDX_IRQSTAT) begin
      rdByte = {4'h0, irqStat_reg};
    end else if (rdDec[7:0] == IDX_IRQMASK) begin
      rdByte = {4'h0, irqMask_reg};
    end else if (rdDec[7:0] == IDX_PINSEL) begin
      rdByte = {7'h00, pinSel_reg};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rdDec[8] ? rdByte : 8'h00};
      rresp  <= rdDec[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  initial begin
    if (ADDR_W < 5 || ADDR_W > 8) $error("asfb_top: ADDR_W must be 5 to 8");
  end

  // ==========================================================================
  // Checks on the documented behaviour.
  property p_tx_gate;
    @(posedge clk) disable iff (!arst_n)
      syncQ[0] |=> !txHoldingEmptyFlag[0];
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("empty flag not held by pin");

  property p_tx_pass;
    @(posedge clk) disable iff (!arst_n)
      (!syncQ[0] && txHoldingEmptyRaw[0]) |=> txHoldingEmptyFlag[0];
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("empty flag lost while pin low");

  property p_ch1_unsel;
    @(posedge clk) disable iff (!arst_n)
      (!pinSel_reg && txHoldingEmptyRaw[1]) |=> txHoldingEmptyFlag[1];
  endproperty
  a_ch1_unsel: assert property (p_ch1_unsel) else $error("ch1 gated while unselected");

  property p_frame_len;
    @(posedge clk) disable iff (!arst_n)
      ($stable(ctrlA_reg[0]) && $stable(ctrlB_reg[0]) && ctrlB_reg[0][CB_MPFMT]
       && !ctrlA_reg[0][CA_LEN] && !ctrlA_reg[0][CA_STOP])
      |=> frameLength[0] == 4'ha;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("multiprocessor frame length");

  property p_parity_off;
    @(posedge clk) disable iff (!arst_n)
      ctrlB_reg[1][CB_MPFMT] |=> !parityActive[1];
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity active in mp format");

  property p_marker;
    @(posedge clk) disable iff (!arst_n)
      $changed(ctrlB_reg[0][CB_MPTX]) |=> multiprocTxBit[0] == $past(ctrlB_reg[0][CB_MPTX]);
  endproperty
  a_marker: assert property (p_marker) else $error("marker bit not forwarded");

  property p_filter;
    @(posedge clk) disable iff (!arst_n)
      (rxCharDone[0] && ctrlB_reg[0][CB_MPFMT] && ctrlA_reg[0][CA_WAKE]) |->
        rxFlagUpdate[0] == rxAddressMarker[0];
  endproperty
  a_filter: assert property (p_filter) else $error("wakeup filter wrong");

  property p_ch1_dma;
    @(posedge clk) disable iff (!arst_n)
      ctrlA_reg[1][CA_CKDMA] |-> ch1ClockPinOe && ch1ClockPinOut == dmaEndOfTransfer;
  endproperty
  a_ch1_dma: assert property (p_ch1_dma) else $error("ch1 pin not driving DMA end");

  property p_irq;
    @(posedge clk) disable iff (!arst_n)
      (irqEvt[0] && irqMask_reg[0]) |=> irq [*2];
  endproperty
  a_irq: assert property (p_irq) else $error("event did not raise interrupt");

  property p_wr_resp;
    @(posedge clk) disable iff (!arst_n)
      (awvalid && awready && wvalid && wready) |=> ##1 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
endmodule : asfb_top

/* dv/asfb_far_end.sv */
`timescale 1ns/10ps
// ==========================================
// Remote party: handshake pins and a pin clock that stands low outside runs.
module asfb_far_end (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ctsCh0,
  input  wire logic ctsCh1,
  input  wire logic run,
  output logic      ch0ClearToSendN,
  output logic      ch1ClearToSendN,
  output logic      extClk
);
  logic [1:0] cnt;
  assign ch0ClearToSendN = ctsCh0;
  assign ch1ClearToSendN = ctsCh1;
  // Pin clock of eight system clocks; idle low so no stray edge reaches the sampler.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n || !run) begin
      cnt    <= 2'h0;
      extClk <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) extClk <= ~extClk;
    end
  end
endmodule : asfb_far_end

/* dv/tb_top.sv */
`timescale 1ns/10ps
// ==========================================
// Register-level bench.
module tb_top;
  import asfb_pkg::*;
  logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic ch0ClearToSendN, ch1ClearToSendN, ch0ClockPin, ch1ClockPinIn, ch1ClockPinOut, ch1ClockPinOe;
  logic ch0ClockPinIsDmaReq, dmaCh0MemIo, dmaEndOfTransfer, cts0, ch1_clear_to_send_pin, run, extClk;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, txHoldingEmptyRaw, txHoldingEmptyFlag, txParityBit, rxCharDone, rxAddressMarker;
  logic [1:0] rxFlagUpdate, dataLengthSelect, parityActive, oddParitySelect, stopCountSelect;
  logic [1:0] multiprocFormatEnable, multiprocTxBit, sampleTick, bitTick;
  logic [1:0][7:0] txData;
  logic [1:0][3:0] frameLength;
  int n_mismatch = 0, n_tests = 0, n;
  // The shared channel 1 pin carries the design's drive while enabled.
  assign ch1ClockPinIn = ch1ClockPinOe ? ch1ClockPinOut : extClk;
  assign ch0ClockPin = extClk;
  asfb_top asfb_top_i (.*);
  asfb_far_end asfb_far_end_i (.clk(clk), .arst_n(arst_n), .ctsCh0(cts0), .ctsCh1(ch1_clear_to_send_pin), .run(run),
    .ch0ClearToSendN(ch0ClearToSendN), .ch1ClearToSendN(ch1ClearToSendN), .extClk(extClk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // Handshakes are sampled mid-cycle and retired at the next rising edge.
  // The response readies stay high between transfers, so that back-to-back calls
  // never lower and raise them again within one time step.
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge clk); ta = awvalid & awready; tw = wvalid & wready; tb = bvalid & bready; r = bresp;
      @(posedge clk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask : wr
  task rd(input logic [7:0] a);
    logic ta, tb;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk); ta = arvalid & arready; tb = rvalid & rready; d = rdata[7:0]; r = rresp;
      @(posedge clk); if (ta) arvalid <= 1'b0;
    end while (!tb);
  endtask : rd
  // The first span after a change is discarded because it starts mid-count.
  task per(input int c, input bit s);
    repeat (2) begin
      n = 0;
      do begin @(negedge clk); n++; end while (!(s ? sampleTick[c] : bitTick[c]));
    end
  endtask : per
  task conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, dmaCh0MemIo, dmaEndOfTransfer, cts0, ch1_clear_to_send_pin, run} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; txHoldingEmptyRaw = 2'h3;
    txData = {8'h00, 8'h81}; rxCharDone = '0; rxAddressMarker = '0; arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(8'h08); chk("ctlb0", d & 8'h7f, 8'h07);
    rd(8'h1c); chk("unmapped", r, RESP_SLVERR);
    chk("pins0", {ch0ClockPinIsDmaReq, ch1ClockPinOe}, 2'h0);
    wr(8'h1c, 8'h00); chk("unmapw", r, RESP_SLVERR);
    wr(8'h00, 8'h07); wr(8'h08, 8'h17); @(negedge clk);
    chk("len", dataLengthSelect[0], 1'b1);
    chk("frm", frameLength[0], 4'hc);
    chk("par", txParityBit[0], 1'b1);
    chk("stop", stopCountSelect[0], 1'b1);
    chk("odd", oddParitySelect[0], 1'b1);
    @(posedge clk); wr(8'h00, 8'h02); @(negedge clk);
    chk("frm7", frameLength[0], 4'ha);
    chk("stop1", stopCountSelect[0], 1'b0);
    chk("par7", txParityBit[0], 1'b0);
    @(posedge clk); wr(8'h08, 8'hc7); @(negedge clk);
    chk("mpen", parityActive[0], 1'b0);
    chk("mpfrm", frameLength[0], 4'ha);
    chk("mptx", multiprocTxBit[0], 1'b1);
    chk("mpfmt", multiprocFormatEnable[0], 1'b1);
    @(posedge clk); wr(8'h08, 8'h47); @(negedge clk);
    chk("mptx0", multiprocTxBit[0], 1'b0);
    @(posedge clk); run <= 1'b1; per(0, 1); chk("ext", n, 8);
    @(posedge clk); run <= 1'b0; wr(8'h00, 8'h82);
    rxCharDone <= 2'h1; @(negedge clk); chk("wake0", rxFlagUpdate[0], 1'b0);
    @(posedge clk); rxAddressMarker <= 2'h1; @(negedge clk); chk("wake1", rxFlagUpdate[0], 1'b1);
    @(posedge clk); rxCharDone <= 2'h0; @(negedge clk); chk("irqm", irq, 1'b0);
    @(posedge clk); wr(8'h14, 8'h01); @(negedge clk); chk("irq", irq, 1'b1);
    @(posedge clk); wr(8'h10, 8'h01); @(negedge clk); chk("irqc", irq, 1'b0);
    @(posedge clk); wr(8'h08, 8'h00); per(0, 0); chk("baud0", n, 160);
    @(posedge clk); wr(8'h0c, 8'h39); per(1, 0); chk("baud1", n, 3840);
    @(posedge clk); cts0 <= 1'b1; ch1_clear_to_send_pin <= 1'b1; repeat (4) @(posedge clk); @(negedge clk);
    chk("tde", txHoldingEmptyFlag, 2'h2);
    @(posedge clk); rd(8'h08); chk("cts0", d[5], 1'b1);
    rd(8'h0c); chk("cts1off", d[5], 1'b0);
    wr(8'h18, 8'h01); repeat (4) @(posedge clk);
    rd(8'h0c); chk("ch1_clear_to_send_pin", d[5], 1'b1);
    dmaCh0MemIo <= 1'b1; dmaEndOfTransfer <= 1'b1; wr(8'h04, 8'h10); @(negedge clk);
    chk("tde1", txHoldingEmptyFlag, 2'h0);
    chk("dreq", ch0ClockPinIsDmaReq, 1'b1);
    chk("tend", {ch1ClockPinOut, ch1ClockPinOe}, 2'h3);
    conclude();
  end
endmodule : tb_top
